// ### src/scsi_irq_reset.sv
// Purpose: interrupt, DMA halt and reset logic of a SCSI bus controller
// Assumes: all inputs synchronous to mclk_i
// Notes:   control bits arrive as plain ports
//
// Summary of operation
// - Mismatch halts DMA, DMA-active bit kept
// - Clearing DMA-active ends DMA, drops request
// - Last received byte stays readable
// - One interrupt output for six sources
// - Interrupt held until clear access or reset
// - Selection: SEL, ID match, bus idle
// - Any ID bit match; zero disables
// - Valid end strobe sets done flag; interrupt only if enabled
// - End strobe needs grant plus strobe
// - Busy loss interrupt when monitoring enabled
// - Parity interrupt needs both enables
// - Bus reset interrupt, release after delay
// - Reset not held in bus status
// - Phase lines compared continuously
// - Mismatch stops request, never drives data
// - Clearing DMA-active disables mismatch interrupt
// - Chip reset clears all, no bus reset
// - Bus reset clears all but latch, bit
// - Issued reset held until bit cleared
// - Busy loss disables outputs, clears DMA
`timescale 1ns/1ps
`default_nettype none
`include "scsi_irq_defines.svh"
module scsi_irq_reset #(
  parameter int SETTLE_CYC = `SETTLE_CYC,
  parameter int CLEAR_CYC  = `CLEAR_CYC
) (
  input  wire logic                   mclk_i,
  input  wire logic                   rst_b_i,
  input  wire scsi_irq_pkg::scsi_in_t scsi_i,
  input  wire scsi_irq_pkg::dma_in_t  dma_i,
  input  wire logic                   dma_mode_wr_i,
  input  wire logic                   dma_mode_val_i,
  input  wire logic                   assert_rst_wr_i,
  input  wire logic                   assert_rst_val_i,
  input  wire logic                   irq_clear_i,
  input  wire logic [`ID_W-1:0]       id_select_i,
  input  wire logic [2:0]             tgt_phase_i,
  input  wire logic                   monitor_busy_i,
  input  wire logic                   parity_chk_en_i,
  input  wire logic                   parity_irq_en_i,
  input  wire logic                   process_end_irq_en_i,
  input  wire logic                   parity_err_i,
  input  wire logic                   assert_data_bus_i,
  input  wire logic                   byte_need_i,
  input  wire logic                   rx_byte_valid_i,
  input  wire logic [7:0]             rx_byte_i,
  output logic                        irq_o,
  output logic                        transfer_request_out_o,
  output logic                        dma_active_o,
  output logic                        transfer_done_flag_o,
  output logic                        phase_match_o,
  output logic                        busy_error_o,
  output logic                        parity_error_o,
  output logic                        selected_o,
  output logic                        reselect_o,
  output logic                        req_recog_o,
  output logic                        bus_release_o,
  output logic                        data_oe_b_o,
  output logic                        rst_drive_o,
  output logic                        rst_oe_b_o,
  output logic [7:0]                  input_data_o
);
  import scsi_irq_pkg::*;

  if (SETTLE_CYC < 1 || SETTLE_CYC > 255 || CLEAR_CYC < 1 || CLEAR_CYC > 255) begin : g_bad_count
    $error("counts must lie in 1..255");
  end

  localparam logic [`CNT_W-1:0] SETTLE_N = SETTLE_CYC[`CNT_W-1:0];
  localparam logic [`CNT_W-1:0] CLEAR_N  = CLEAR_CYC[`CNT_W-1:0];
  localparam int REL_DLY = CLEAR_CYC + 2;
  localparam logic [`CNT_W:0] REL_N = REL_DLY[`CNT_W:0];

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic              irq_r;
  logic              drq_r;
  logic              dma_active_r;
  logic              done_r;
  logic              halted_r;
  logic              phase_match_r;
  logic              busy_err_r;
  logic              parity_err_r;
  logic              sel_r;
  logic              resel_r;
  logic              req_recog_r;
  logic              release_r;
  logic              data_oe_b_r;
  logic              assert_rst_r;
  logic              rst_oe_b_r;
  logic [7:0]        in_data_r;
  logic [`CNT_W-1:0] idle_cnt_r;
  logic [`CNT_W-1:0] clr_cnt_r;
  logic              rst_seen_r;
  logic              sel_cond_r;
  logic              eop_cond_r;
  rst_state_t        rst_state_r;

  // ---------------------------------------------------------------
  // Event detection
  // ---------------------------------------------------------------
  logic rst_seen;
  logic rst_evt;
  logic idle_ok;
  logic phase_ok;
  logic sel_cond;
  logic sel_evt;
  logic busy_evt;
  logic mis_cond;
  logic mis_evt;
  logic eop_cond;
  logic eop_evt;
  logic par_evt;
  logic irq_set;
  logic sw_clear_dma;

  // Issued reset is seen like a received one
  assign rst_seen     = scsi_i.rst | assert_rst_r;
  assign rst_evt      = rst_seen & ~rst_seen_r;
  assign idle_ok      = (idle_cnt_r == SETTLE_N);
  assign phase_ok     = ({scsi_i.io, scsi_i.cd, scsi_i.msg} == tgt_phase_i);
  assign sel_cond     = scsi_i.sel & (|(scsi_i.bus_data_lines & id_select_i)) & idle_ok;
  assign sel_evt      = sel_cond & ~sel_cond_r;
  assign busy_evt     = monitor_busy_i & idle_ok & ~busy_err_r;
  assign mis_cond     = dma_active_r & scsi_i.req & ~phase_match_r;
  assign mis_evt      = mis_cond & ~halted_r;
  assign eop_cond     = dma_active_r & dma_i.eop & dma_i.grant & (dma_i.rd | dma_i.wr);
  assign eop_evt      = eop_cond & ~eop_cond_r;
  assign par_evt      = parity_err_i & parity_chk_en_i & ~parity_err_r;
  assign sw_clear_dma = dma_mode_wr_i & ~dma_mode_val_i;
  // Bus reset cannot be masked
  assign irq_set = sel_evt | (eop_evt & process_end_irq_en_i) | busy_evt
                 | (par_evt & parity_irq_en_i) | rst_evt | mis_evt;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_seen_r <= 1'b0;
      sel_cond_r <= 1'b0;
      eop_cond_r <= 1'b0;
    end else begin
      rst_seen_r <= rst_seen;
      sel_cond_r <= sel_cond;
      eop_cond_r <= eop_cond;
    end
  end

  // Idle time of BSY, saturating
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      idle_cnt_r <= '0;
    end else if (scsi_i.bsy) begin
      idle_cnt_r <= '0;
    end else if (!idle_ok) begin
      idle_cnt_r <= idle_cnt_r + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt latch
  // ---------------------------------------------------------------
  // Kept through bus reset; set wins over clear
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_r <= 1'b0;
    end else if (irq_set) begin
      irq_r <= 1'b1;
    end else if (irq_clear_i) begin
      irq_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sel_r   <= 1'b0;
      resel_r <= 1'b0;
    end else if (sel_evt) begin
      sel_r   <= 1'b1;
      resel_r <= scsi_i.io;
    end else if (irq_clear_i || rst_seen) begin
      sel_r   <= 1'b0;
      resel_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      parity_err_r <= 1'b0;
    end else if (par_evt) begin
      parity_err_r <= 1'b1;
    end else if (irq_clear_i || rst_seen) begin
      parity_err_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_err_r <= 1'b0;
    end else if (busy_evt) begin
      busy_err_r <= 1'b1;
    end else if (irq_clear_i || !monitor_busy_i || rst_seen) begin
      busy_err_r <= 1'b0;
    end
  end

  // Continuous compare, one cycle behind the lines
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase_match_r <= 1'b0;
    end else begin
      phase_match_r <= phase_ok;
    end
  end

  // ---------------------------------------------------------------
  // DMA control
  // ---------------------------------------------------------------
  // End strobe clears the mode only after a mismatch halt
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dma_active_r <= 1'b0;
    end else if (rst_seen || busy_evt) begin
      dma_active_r <= 1'b0;
    end else if (eop_evt && halted_r) begin
      dma_active_r <= 1'b0;
    end else if (dma_mode_wr_i) begin
      dma_active_r <= dma_mode_val_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      halted_r <= 1'b0;
    end else if (rst_seen || !dma_active_r) begin
      halted_r <= 1'b0;
    end else if (mis_evt) begin
      halted_r <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      done_r <= 1'b0;
    end else if (eop_evt) begin
      done_r <= 1'b1;
    end else if (rst_seen || !dma_active_r) begin
      done_r <= 1'b0;
    end
  end

  // Late clear in target receive costs one extra REQ
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      drq_r <= 1'b0;
    end else if (sw_clear_dma || rst_seen || busy_evt || mis_evt || halted_r) begin
      drq_r <= 1'b0;
    end else if (dma_i.grant) begin
      drq_r <= 1'b0;
    end else if (byte_need_i && dma_active_r) begin
      drq_r <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_recog_r <= 1'b0;
    end else begin
      req_recog_r <= dma_active_r & ~halted_r & ~mis_cond & ~rst_seen;
    end
  end

  // Input byte survives the transfer_done_flag
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      in_data_r <= 8'h00;
    end else if (rst_seen) begin
      in_data_r <= 8'h00;
    end else if (rx_byte_valid_i) begin
      in_data_r <= rx_byte_i;
    end
  end

  // ---------------------------------------------------------------
  // Bus reset sequence
  // ---------------------------------------------------------------
  // Only the software bit drives RST; chip reset never does
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      assert_rst_r <= 1'b0;
      rst_oe_b_r   <= 1'b1;
    end else begin
      if (assert_rst_wr_i) begin
        assert_rst_r <= assert_rst_val_i;
      end
      rst_oe_b_r <= ~(assert_rst_wr_i ? assert_rst_val_i : assert_rst_r);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_state_r <= RS_IDLE;
      clr_cnt_r   <= '0;
    end else begin
      unique case (rst_state_r)
        RS_IDLE: begin
          clr_cnt_r <= '0;
          if (rst_evt) begin
            rst_state_r <= RS_HOLD;
          end
        end
        RS_HOLD: begin
          clr_cnt_r <= clr_cnt_r + 8'h01;
          if (clr_cnt_r == CLEAR_N - 8'h01) begin
            rst_state_r <= RS_RELEASED;
          end
        end
        RS_RELEASED: begin
          if (!rst_seen) begin
            rst_state_r <= RS_IDLE;
          end
        end
        default: begin
          rst_state_r <= RS_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Bus drivers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      release_r   <= 1'b0;
      data_oe_b_r <= 1'b1;
    end else begin
      release_r   <= (rst_state_r == RS_RELEASED) | busy_err_r | busy_evt;
      data_oe_b_r <= ~(assert_data_bus_i & phase_ok & ~halted_r & ~mis_cond
                       & ~release_r & ~busy_err_r & ~busy_evt & ~rst_seen);
    end
  end

  // Reset state deliberately absent from status outputs
  assign irq_o                  = irq_r;
  assign transfer_request_out_o = drq_r;
  assign dma_active_o           = dma_active_r;
  assign transfer_done_flag_o   = done_r;
  assign phase_match_o          = phase_match_r;
  assign busy_error_o           = busy_err_r;
  assign parity_error_o         = parity_err_r;
  assign selected_o             = sel_r;
  assign reselect_o             = resel_r;
  assign req_recog_o            = req_recog_r;
  assign bus_release_o          = release_r;
  assign data_oe_b_o            = data_oe_b_r;
  assign rst_drive_o            = assert_rst_r;
  assign rst_oe_b_o             = rst_oe_b_r;
  assign input_data_o           = in_data_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  // Cycles of RST held; a counter, as the hold is too long to unroll
  logic [`CNT_W:0] rst_hold_cnt_r;
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_hold_cnt_r <= '0;
    end else if (!rst_seen) begin
      rst_hold_cnt_r <= '0;
    end else if (rst_hold_cnt_r != REL_N) begin
      rst_hold_cnt_r <= rst_hold_cnt_r + 9'h001;
    end
  end

  sequence s_rst_held;
    rst_hold_cnt_r == REL_N;
  endsequence
  sequence s_bus_freed;
    bus_release_o;
  endsequence

  chk_drq_on_clear:  assert property (sw_clear_dma |=> !transfer_request_out_o)
    else $error("request not dropped on DMA clear");
  chk_halt_keeps_mode: assert property (mis_evt && !rst_seen && !busy_evt && !dma_mode_wr_i
    |=> dma_active_o && !transfer_request_out_o && !req_recog_o)
    else $error("mismatch halt lost the DMA mode");
  chk_irq_hold_clear: assert property (irq_o && !irq_clear_i |=> irq_o)
    else $error("interrupt dropped without clear");
  chk_irq_needs_cause: assert property ($rose(irq_o) |-> $past(irq_set))
    else $error("interrupt without a source");
  chk_sel_idle_time: assert property ($rose(selected_o) |-> $past(idle_cnt_r) == SETTLE_N)
    else $error("selection before bus settle");
  chk_busy_loss_dma: assert property ($rose(busy_error_o) |-> !dma_active_o ##1 bus_release_o)
    else $error("busy loss left DMA or drivers on");
  chk_eop_done_flag: assert property (eop_evt && process_end_irq_en_i |=> transfer_done_flag_o && irq_o)
    else $error("end strobe missed flag or interrupt");
  chk_parity_gate:  assert property ($rose(parity_error_o) |-> $past(parity_chk_en_i))
    else $error("parity flag without check enable");
  chk_rst_release:  assert property (s_rst_held |-> s_bus_freed)
    else $error("bus not released after clear delay");
  chk_mismatch_nodrive: assert property (mis_cond |=> data_oe_b_o)
    else $error("data driven during mismatch");
  chk_rst_hold_bit: assert property (assert_rst_r && !assert_rst_wr_i |=> !rst_oe_b_o)
    else $error("issued reset not held");
endmodule
`default_nettype wire

// ### src/scsi_irq_defines.svh
// Purpose: timing and field constants of the interrupt/reset block
// Assumes: 40 MHz clock
// Notes:   counts derived from times in ns
`ifndef SCSI_IRQ_DEFINES_SVH
`define SCSI_IRQ_DEFINES_SVH
`define CLK_PERIOD_NS  25
`define BUS_SETTLE_NS  400
`define BUS_CLEAR_NS   800
// Least times, rounded up
`define SETTLE_CYC     ((`BUS_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CLEAR_CYC      ((`BUS_CLEAR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W          8
`define ID_W           8
`endif

// ### src/scsi_irq_pkg.sv
// Purpose: types of the interrupt/reset block
// Assumes: nothing
// Notes:   bus and strobe groups as packed structs
package scsi_irq_pkg;
  typedef struct packed {
    logic       sel;
    logic       bsy;
    logic       io;
    logic       cd;
    logic       msg;
    logic       req;
    logic       rst;
    logic [7:0] bus_data_lines;
  } scsi_in_t;
  typedef struct packed {
    logic grant;
    logic rd;
    logic wr;
    logic eop;
  } dma_in_t;
  typedef enum logic [1:0] {
    RS_IDLE     = 2'h0,
    RS_HOLD     = 2'h1,
    RS_RELEASED = 2'h3
  } rst_state_t;
endpackage

// ### verif/dma_host_model.sv
// Purpose: DMA controller model at the far side of the block
// Assumes: block outputs sampled on the rising clock edge
// Notes:   grant held until the request drops, eight cycles at most
`timescale 1ns/1ps
`default_nettype none
module dma_host_model (
  input  wire logic                  mclk_i,
  input  wire logic                  drq_i,
  input  wire logic                  en_i,
  input  wire logic                  wr_i,
  input  wire logic                  eop_i,
  input  wire logic                  stb_i,
  input  wire logic [3:0]            dly_i,
  output var  scsi_irq_pkg::dma_in_t dma_o
);
  import scsi_irq_pkg::*;
  dma_in_t nxt;
  int      n;
  // ------------
  // Grant cycle
  // ------------
  initial begin
    dma_o = '0;
    forever begin
      @(posedge mclk_i);
      if (en_i && drq_i) begin
        // Late grant leaves the host room to drop DMA-active
        repeat (dly_i) @(posedge mclk_i);
        nxt = {1'b1, stb_i & ~wr_i, stb_i & wr_i, eop_i};
        #1;
        dma_o = nxt;
        n = 0;
        do begin
          @(posedge mclk_i);
          n++;
        end while (drq_i && n < 8);
        #1;
        dma_o = '0;
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/scsi_irq_reset_tb.sv
// Purpose: self-checking bench of the interrupt/reset block
// Assumes: settle and clear counts shortened to 2 and 3
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module scsi_irq_reset_tb;
  import scsi_irq_pkg::*;
  localparam int SC = 2;
  localparam int CC = 3;
  logic       mclk_i, rst_b_i, dm_wr, dm_val, ar_wr, ar_val, clr;
  logic       mon, pchk, pirq, eirq, perr, adb, need, rxv;
  logic       h_en, h_wr, h_eop, h_stb;
  logic [3:0] h_dly;
  logic [2:0] tphase;
  logic [7:0] id_sel, rx_byte, idata;
  logic       irq, transfer_request_out, act, done, pm, berr, pflag, sel_f, resel, recog, rel, doe_b, rdrv, roe_b;
  scsi_in_t   scsi;
  dma_in_t    dma;
  int         errors, samples_checked, i;
  int         seed = 32'h5910A877;
  logic [7:0] exp_q[$];

  scsi_irq_reset #(.SETTLE_CYC(SC), .CLEAR_CYC(CC)) scsi_irq_reset_i (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .scsi_i(scsi), .dma_i(dma), .dma_mode_wr_i(dm_wr),
    .dma_mode_val_i(dm_val), .assert_rst_wr_i(ar_wr), .assert_rst_val_i(ar_val), .irq_clear_i(clr),
    .id_select_i(id_sel), .tgt_phase_i(tphase), .monitor_busy_i(mon), .parity_chk_en_i(pchk),
    .parity_irq_en_i(pirq), .process_end_irq_en_i(eirq), .parity_err_i(perr), .assert_data_bus_i(adb),
    .byte_need_i(need), .rx_byte_valid_i(rxv), .rx_byte_i(rx_byte), .irq_o(irq),
    .transfer_request_out_o(transfer_request_out), .dma_active_o(act), .transfer_done_flag_o(done), .phase_match_o(pm),
    .busy_error_o(berr), .parity_error_o(pflag), .selected_o(sel_f), .reselect_o(resel),
    .req_recog_o(recog), .bus_release_o(rel), .data_oe_b_o(doe_b), .rst_drive_o(rdrv),
    .rst_oe_b_o(roe_b), .input_data_o(idata));

  dma_host_model dma_host_model_i (.mclk_i(mclk_i), .drq_i(transfer_request_out), .en_i(h_en), .wr_i(h_wr),
    .eop_i(h_eop), .stb_i(h_stb), .dly_i(h_dly), .dma_o(dma));

  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  // --------------
  // Shared tasks
  // --------------
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic set_dma(input logic v);
    dm_val = v;
    dm_wr = 1'b1;
    tick(1);
    dm_wr = 1'b0;
  endtask

  task automatic set_ar(input logic v);
    ar_val = v;
    ar_wr = 1'b1;
    tick(1);
    ar_wr = 1'b0;
  endtask

  task automatic pulse_clr;
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
  endtask

  // Bounded wait; a hang ends the run
  task automatic wait_drq(input logic v);
    int n;
    for (n = 0; n < 20 && transfer_request_out !== v; n++)
      tick(1);
    chk_bit("drq", v, transfer_request_out);
    if (transfer_request_out !== v)
      test_done();
  endtask

  task automatic test_done;
    if (errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #1000000;
    errors++;
    test_done();
  end

  // ----------
  // Sequence
  // ----------
  initial begin
    {rst_b_i, dm_wr, dm_val, ar_wr, ar_val, clr, mon, pchk, pirq, eirq, perr, adb, need, rxv} = '0;
    {h_en, h_wr, h_eop, h_stb, h_dly, tphase, rx_byte} = {4'h1, 4'h2, 3'h0, 8'h00};
    id_sel = 8'h24;
    scsi = '0;
    scsi.bsy = 1'b1;
    scsi.bus_data_lines = 8'h04;
    tick(10);
    rst_b_i = 1'b1;
    tick(1);
    chk_bit("irq", 1'b0, irq);
    chk_bit("rst_oe_b", 1'b1, roe_b);
    // Selection just as the bus goes idle, then after the settle time
    scsi.bsy = 1'b0;
    scsi.sel = 1'b1;
    tick(1);
    chk_bit("irq", 1'b0, irq);
    for (i = 0; i < 2; i++) begin
      scsi.io = i[0];
      scsi.sel = 1'b1;
      tick(SC + 3);
      chk_bit("irq", 1'b1, irq);
      chk_bit("selected", 1'b1, sel_f);
      chk_bit("reselect", i[0], resel);
      scsi.sel = 1'b0;
      pulse_clr();
      chk_bit("irq", 1'b0, irq);
    end
    id_sel = 8'h00;
    scsi.sel = 1'b1;
    tick(SC + 3);
    chk_bit("irq", 1'b0, irq);
    {scsi.sel, scsi.io, scsi.bsy} = 3'h1;
    // DMA bytes with random grant delay and direction
    set_dma(1'b1);
    need = 1'b1;
    h_en = 1'b1;
    for (i = 0; i < 4; i++) begin
      h_dly = 4'($random(seed) & 3);
      h_wr = 1'($random(seed));
      wait_drq(1'b1);
      wait_drq(1'b0);
    end
    h_dly = 4'h6;
    wait_drq(1'b1);
    set_dma(1'b0);
    chk_bit("drq", 1'b0, transfer_request_out);
    chk_bit("dma_active", 1'b0, act);
    tick(12);
    chk_bit("drq", 1'b0, transfer_request_out);
    // End strobe without read or write strobe, then valid ones
    {eirq, h_eop, h_stb, h_dly} = {3'h6, 4'h1};
    set_dma(1'b1);
    tick(14);
    chk_bit("done", 1'b0, done);
    chk_bit("irq", 1'b0, irq);
    h_en = 1'b0;
    tick(14);
    h_stb = 1'b1;
    for (i = 0; i < 2; i++) begin
      eirq = i[0];
      wait_drq(1'b1);
      h_en = 1'b1;
      wait_drq(1'b0);
      h_en = 1'b0;
      tick(3);
      chk_bit("done", 1'b1, done);
      chk_bit("irq", i[0], irq);
      chk_bit("dma_active", 1'b1, act);
      pulse_clr();
      set_dma(1'b0);
      // Done flag follows the DMA-active bit one cycle later
      tick(1);
      chk_bit("done", 1'b0, done);
      set_dma(1'b1);
    end
    tick(1);
    set_dma(1'b0);
    {need, h_eop} = 2'h0;
    // Phase compare, then a mismatch while DMA runs
    for (i = 0; i < 6; i++) begin
      tphase = 3'($random(seed));
      {scsi.io, scsi.cd, scsi.msg} = 3'($random(seed));
      tick(2);
      chk_bit("phase_match", tphase === {scsi.io, scsi.cd, scsi.msg}, pm);
    end
    {tphase, scsi.io, scsi.cd, scsi.msg, adb, need} = {3'h2, 3'h3, 2'h3};
    set_dma(1'b1);
    tick(2);
    scsi.req = 1'b1;
    tick(1);
    chk_bit("irq", 1'b1, irq);
    chk_bit("drq", 1'b0, transfer_request_out);
    chk_bit("req_recog", 1'b0, recog);
    chk_bit("data_oe_b", 1'b1, doe_b);
    chk_bit("dma_active", 1'b1, act);
    {scsi.req, need} = 2'h0;
    pulse_clr();
    set_dma(1'b0);
    chk_bit("dma_active", 1'b0, act);
    scsi.req = 1'b1;
    tick(3);
    chk_bit("irq", 1'b0, irq);
    // Matched phase with data drive asked: lines are driven
    {scsi.req, adb, tphase} = {2'h1, 3'h3};
    tick(2);
    chk_bit("data_oe_b", 1'b0, doe_b);
    // Parity error under every pair of enables
    for (i = 0; i < 4; i++) begin
      {pirq, pchk} = 2'(i);
      perr = 1'b1;
      tick(1);
      perr = 1'b0;
      tick(1);
      chk_bit("irq", i == 3, irq);
      chk_bit("parity_flag", pchk, pflag);
      pulse_clr();
    end
    // Busy loss with monitoring on, then off
    mon = 1'b1;
    set_dma(1'b1);
    scsi.bsy = 1'b0;
    tick(1);
    chk_bit("busy_err", 1'b0, berr);
    tick(SC + 3);
    chk_bit("busy_err", 1'b1, berr);
    chk_bit("irq", 1'b1, irq);
    chk_bit("dma_active", 1'b0, act);
    chk_bit("release", 1'b1, rel);
    chk_bit("data_oe_b", 1'b1, doe_b);
    {scsi.bsy, mon} = 2'h2;
    pulse_clr();
    scsi.bsy = 1'b0;
    tick(SC + 3);
    chk_bit("busy_err", 1'b0, berr);
    scsi.bsy = 1'b1;
    // Received bytes stay readable after DMA ends
    set_dma(1'b1);
    rxv = 1'b1;
    for (i = 0; i < 3; i++) begin
      rx_byte = 8'($random(seed));
      exp_q.push_back(rx_byte);
      tick(1);
      chk_byte("input_data", exp_q.pop_front(), idata);
    end
    rxv = 1'b0;
    set_dma(1'b0);
    tick(2);
    chk_byte("input_data", rx_byte, idata);
    // Bus reset from the cable
    set_dma(1'b1);
    scsi.rst = 1'b1;
    tick(2);
    chk_bit("irq", 1'b1, irq);
    chk_bit("dma_active", 1'b0, act);
    set_dma(1'b1);
    chk_bit("dma_active", 1'b0, act);
    tick(CC + 4);
    chk_bit("release", 1'b1, rel);
    chk_bit("irq", 1'b1, irq);
    scsi.rst = 1'b0;
    tick(2);
    pulse_clr();
    chk_bit("irq", 1'b0, irq);
    // Reset issued by the assert-reset bit
    set_ar(1'b1);
    tick(1);
    chk_bit("rst_drive", 1'b1, rdrv);
    chk_bit("rst_oe_b", 1'b0, roe_b);
    chk_bit("irq", 1'b1, irq);
    tick(CC + 4);
    chk_bit("rst_drive", 1'b1, rdrv);
    set_ar(1'b0);
    chk_bit("rst_drive", 1'b0, rdrv);
    tick(2);
    set_ar(1'b1);
    rst_b_i = 1'b0;
    tick(2);
    chk_bit("rst_drive", 1'b0, rdrv);
    chk_bit("rst_oe_b", 1'b1, roe_b);
    chk_bit("data_oe_b", 1'b1, doe_b);
    chk_bit("irq", 1'b0, irq);
    rst_b_i = 1'b1;
    tick(2);
    test_done();
  end
endmodule
`default_nettype wire
